/* src/pfs_pkg.sv */
/*
   Constants for the function status flag block: register placement in
   configuration space, bit layout, reset value and access states.
   Assumes dword-wide configuration accesses with byte enables.
*/
package pfs_pkg;

   // Register placement
   localparam logic [11:0] FUNC_STATUS_OFS = 12'h04a;
   localparam logic [9:0] FUNC_STATUS_DW = FUNC_STATUS_OFS[11:2];
   localparam logic [1:0] FUNC_STATUS_LANE = FUNC_STATUS_OFS[1:0];
   localparam int CFG_DW_W = 10;
   localparam int CFG_DATA_W = 32;
   localparam int CFG_BE_W = 4;

   // Register layout
   localparam int STS_W = 16;
   localparam logic [15:0] STS_RESET = 16'h0000;
   localparam int BIT_CORR = 0;
   localparam int BIT_NONFATAL = 1;
   localparam int BIT_FATAL = 2;
   localparam int BIT_UNSUP = 3;
   localparam int BIT_PEND = 5;
   localparam int ERR_FLAGS = 4;
   localparam logic [3:0] ERR_RESET = 4'h0;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

   // Outstanding request counter
   localparam int CNT_W_DEF = 11;

   // Configuration access handler
   typedef enum logic [1:0]
   {
      PFS_IDLE = 2'b00,
      PFS_RESP = 2'b01
   } pfs_acc_e;

endpackage

/* src/pfs_pending_tracker.sv */
/*
   Outstanding non-posted request tracker. Counts issued requests down
   on real completions and on completion timeouts, clears on the end of
   a function level reset, and flags accounting errors.
   Assumes one-cycle event pulses synchronous to clk_sys.
*/
`timescale 1ns/1ps

module pfs_pending_tracker
#(
   parameter int CNT_W = pfs_pkg::CNT_W_DEF
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Request events
   input wire logic np_issue,
   input wire logic np_complete,
   input wire logic np_timeout,
   input wire logic flr_done,
   // Results
   output logic pending_r,
   output logic [CNT_W-1:0] count_r,
   output logic track_err_r
);

   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_MAX = '1;

   logic [CNT_W+1:0] sum;
   logic [CNT_W+1:0] fin;
   logic [CNT_W-1:0] count_nxt;
   logic err_nxt;

   always_comb
   begin
      sum = {2'b00, count_r} + {{(CNT_W+1){1'b0}}, np_issue};
      // A timed-out request finishes just as a completed one does
      fin = {{(CNT_W+1){1'b0}}, np_complete}
         + {{(CNT_W+1){1'b0}}, np_timeout};
      err_nxt = 1'b0;
      if (fin > sum)
      begin
         count_nxt = CNT_ZERO;
         err_nxt = 1'b1;
      end
      else if ((sum - fin) > {2'b00, CNT_MAX})
      begin
         count_nxt = CNT_MAX;
         err_nxt = 1'b1;
      end
      else
      begin
         count_nxt = CNT_W'(sum - fin);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         count_r <= CNT_ZERO;
         pending_r <= 1'b0;
      end
      else if (flr_done)
      begin
         count_r <= CNT_ZERO;
         pending_r <= 1'b0;
      end
      else
      begin
         count_r <= count_nxt;
         pending_r <= (count_nxt != CNT_ZERO);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         track_err_r <= 1'b0;
      else if (err_nxt && !flr_done)
         track_err_r <= 1'b1;
   end

endmodule

/* src/pfs_function_status.sv */
/*
   Function status register for one PCI Express function in
   configuration space: pending-request flag and four sticky error flags
   cleared by writing ones. Assumes dword configuration accesses with
   byte enables, one-cycle event pulses, and requests spaced at least two
   cycles apart. Error reporting enables and error masks live in other
   registers and never gate the flags kept here, so none of them is an
   input of this block.
*/
`timescale 1ns/1ps

module pfs_function_status
#(
   parameter int CNT_W = pfs_pkg::CNT_W_DEF
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Non-posted request tracking
   input wire logic np_issue,
   input wire logic np_complete,
   input wire logic np_timeout,
   input wire logic flr_done,
   // Error events from classification logic
   input wire logic unsup_req_event,
   input wire logic fatal_err_event,
   input wire logic nonfatal_err_event,
   input wire logic corr_err_event,
   // Configuration access
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [pfs_pkg::CFG_DW_W-1:0] cfg_dw_addr,
   input wire logic [pfs_pkg::CFG_BE_W-1:0] cfg_byte_en,
   input wire logic [pfs_pkg::CFG_DATA_W-1:0] cfg_wdata,
   output logic [pfs_pkg::CFG_DATA_W-1:0] cfg_rdata,
   output logic cfg_done,
   // Status view
   output logic [pfs_pkg::STS_W-1:0] function_status,
   output logic requests_pending,
   output logic [CNT_W-1:0] outstanding_cnt,
   output logic track_err
);

   // Bits in one byte lane of the configuration dword
   localparam int BYTE_W = 8;
   localparam int LANE_LO = BYTE_W * int'(pfs_pkg::FUNC_STATUS_LANE);

   pfs_pkg::pfs_acc_e acc_r;
   pfs_pkg::pfs_acc_e acc_nxt;
   logic [pfs_pkg::ERR_FLAGS-1:0] err_r;
   logic [pfs_pkg::ERR_FLAGS-1:0] err_evt;
   logic [pfs_pkg::ERR_FLAGS-1:0] err_clr;
   logic [pfs_pkg::ERR_FLAGS-1:0] err_nxt;
   logic pend_flag;
   logic [CNT_W-1:0] cnt_q;
   logic trk_err_q;
   logic req_take;
   logic wr_take;
   logic rd_take;
   logic [pfs_pkg::STS_W-1:0] image;
   logic [pfs_pkg::STS_W-1:0] wr_half;
   logic [pfs_pkg::STS_W-1:0] wr_mask;
   logic [pfs_pkg::CFG_DATA_W-1:0] rd_word;
   logic sts_sel;
   logic [pfs_pkg::CFG_DATA_W-1:0] cfg_rdata_r;
   logic cfg_done_r;
   logic [pfs_pkg::STS_W-1:0] function_status_r;
   logic requests_pending_r;
   logic [CNT_W-1:0] outstanding_cnt_r;
   logic track_err_r;

   // True when the access lands on the dword holding the register and
   // enables at least one of its byte lanes
   function automatic logic sts_hit
   (
      input logic [pfs_pkg::CFG_DW_W-1:0] dw,
      input logic [pfs_pkg::CFG_BE_W-1:0] be
   );
      logic lanes;
      lanes = be[int'(pfs_pkg::FUNC_STATUS_LANE)]
         | be[int'(pfs_pkg::FUNC_STATUS_LANE) + 1];
      sts_hit = (dw == pfs_pkg::FUNC_STATUS_DW) && lanes;
   endfunction

   // Builds the register image; reserved bits stay zero
   function automatic logic [pfs_pkg::STS_W-1:0] sts_pack
   (
      input logic [pfs_pkg::ERR_FLAGS-1:0] errs,
      input logic pend
   );
      logic [pfs_pkg::STS_W-1:0] v;
      v = pfs_pkg::STS_RESET;
      v[pfs_pkg::BIT_CORR] = errs[pfs_pkg::BIT_CORR];
      v[pfs_pkg::BIT_NONFATAL] = errs[pfs_pkg::BIT_NONFATAL];
      v[pfs_pkg::BIT_FATAL] = errs[pfs_pkg::BIT_FATAL];
      v[pfs_pkg::BIT_UNSUP] = errs[pfs_pkg::BIT_UNSUP];
      v[pfs_pkg::BIT_PEND] = pend;
      sts_pack = v;
   endfunction

   // Outstanding request accounting
   pfs_pending_tracker #(
      .CNT_W(CNT_W)
   ) u_tracker (
      .clk_sys(clk_sys),
      .rst(rst),
      .np_issue(np_issue),
      .np_complete(np_complete),
      .np_timeout(np_timeout),
      .flr_done(flr_done),
      .pending_r(pend_flag),
      .count_r(cnt_q),
      .track_err_r(trk_err_q)
   );

   // Access handler: one request at a time, answered on the next edge
   always_comb
   begin
      req_take = 1'b0;
      acc_nxt = acc_r;
      case (acc_r)
         pfs_pkg::PFS_IDLE:
         begin
            if (cfg_rd || cfg_wr)
            begin
               req_take = 1'b1;
               acc_nxt = pfs_pkg::PFS_RESP;
            end
         end
         pfs_pkg::PFS_RESP:
         begin
            acc_nxt = pfs_pkg::PFS_IDLE;
         end
         default:
         begin
            acc_nxt = pfs_pkg::PFS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         acc_r <= pfs_pkg::PFS_IDLE;
      else
         acc_r <= acc_nxt;
   end

   // A write wins over a read offered in the same cycle
   always_comb
   begin
      sts_sel = sts_hit(cfg_dw_addr, cfg_byte_en);
      wr_take = req_take && cfg_wr && sts_sel;
      rd_take = req_take && !cfg_wr && sts_sel;
      wr_half = cfg_wdata[LANE_LO +: pfs_pkg::STS_W];
   end

   // Event vector in register bit order; error enables and masks are
   // deliberately not looked at
   function automatic logic [pfs_pkg::ERR_FLAGS-1:0] evt_pack
   (
      input logic ur,
      input logic fatal,
      input logic nonfatal,
      input logic corr
   );
      logic [pfs_pkg::ERR_FLAGS-1:0] v;
      v = pfs_pkg::ERR_RESET;
      v[pfs_pkg::BIT_CORR] = corr;
      v[pfs_pkg::BIT_NONFATAL] = nonfatal;
      v[pfs_pkg::BIT_FATAL] = fatal;
      v[pfs_pkg::BIT_UNSUP] = ur;
      evt_pack = v;
   endfunction

   always_comb
   begin
      err_evt = evt_pack(unsup_req_event, fatal_err_event,
         nonfatal_err_event, corr_err_event);
   end

   // Per-bit write enable from the byte lane that carries each bit
   genvar bi;
   generate
      for (bi = 0; bi < pfs_pkg::STS_W; bi = bi + 1)
      begin : g_lane
         assign wr_mask[bi] =
            cfg_byte_en[int'(pfs_pkg::FUNC_STATUS_LANE) + bi / BYTE_W];
      end
   endgenerate

   genvar gi;
   generate
      for (gi = 0; gi < pfs_pkg::ERR_FLAGS; gi = gi + 1)
      begin : g_flag
         // A flag clears only where its byte lane is enabled
         assign err_clr[gi] = wr_take && wr_mask[gi] && wr_half[gi];
         // Set beats a clear landing in the same cycle
         assign err_nxt[gi] = err_evt[gi]
            | (err_r[gi] & ~err_clr[gi]);

         always_ff @(posedge clk_sys)
         begin
            if (rst)
               err_r[gi] <= pfs_pkg::ERR_RESET[gi];
            else
               err_r[gi] <= err_nxt[gi];
         end
      end
   endgenerate

   always_comb
   begin
      image = sts_pack(err_r, pend_flag);
   end

   // Read word; other dwords and lanes read as zero
   always_comb
   begin
      rd_word = pfs_pkg::DATA_ZERO;
      if (rd_take)
         rd_word[LANE_LO +: pfs_pkg::STS_W] = image;
   end

   // Read answer stands until the next taken request
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         cfg_rdata_r <= pfs_pkg::DATA_ZERO;
      else if (req_take)
         cfg_rdata_r <= rd_word;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         cfg_done_r <= 1'b0;
      else
         cfg_done_r <= req_take;
   end

   // Registered status view for the rest of the function
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         function_status_r <= pfs_pkg::STS_RESET;
      else
         function_status_r <= image;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         requests_pending_r <= 1'b0;
      else
         requests_pending_r <= pend_flag;
   end

   // Count and accounting error copies are not part of the register
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         outstanding_cnt_r <= '0;
      else
         outstanding_cnt_r <= cnt_q;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         track_err_r <= 1'b0;
      else
         track_err_r <= trk_err_q;
   end

   assign cfg_rdata = cfg_rdata_r;
   assign cfg_done = cfg_done_r;
   assign function_status = function_status_r;
   assign requests_pending = requests_pending_r;
   assign outstanding_cnt = outstanding_cnt_r;
   assign track_err = track_err_r;

endmodule

/* dv/pfs_asserts.sv */
/*
   Port checker for the function status block.
   Assumes it is bound to every pfs_function_status instance.
*/
`timescale 1ns/1ps
module pfs_asserts
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Events
   input wire logic np_issue,
   input wire logic np_complete,
   input wire logic np_timeout,
   input wire logic flr_done,
   input wire logic unsup_req_event,
   input wire logic fatal_err_event,
   input wire logic nonfatal_err_event,
   input wire logic corr_err_event,
   // Configuration access and status
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [3:0] cfg_byte_en,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_done,
   input wire logic [15:0] function_status,
   input wire logic requests_pending
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_take;
      (cfg_rd || cfg_wr) && !cfg_done;
   endsequence
   sequence s_answer;
      cfg_done ##1 !cfg_done;
   endsequence
   property p_answer;
      s_take |=> s_answer;
   endproperty
   a_answer: assert property (p_answer) else $error("answer missing");
   property p_rsvd;
      function_status[15:6] == 10'h000 && !function_status[4] &&
      (!cfg_done || (cfg_rdata[31:22] == 10'h000 && !cfg_rdata[20]
      && cfg_rdata[15:0] == 16'h0000));
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_pend_set;
      np_issue && !np_complete && !np_timeout && !flr_done
      |-> ##2 requests_pending;
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("no pending");
   property p_pend_fall;
      $fell(requests_pending)
      |-> $past(np_complete || np_timeout || flr_done, 2);
   endproperty
   a_pend_fall: assert property (p_pend_fall) else $error("early fall");
   property p_flr;
      flr_done |-> ##2 !requests_pending;
   endproperty
   a_flr: assert property (p_flr) else $error("pending after reset");
   property p_ur_set;
      unsup_req_event |-> ##2 function_status[3];
   endproperty
   a_ur_set: assert property (p_ur_set) else $error("flag 3 not set");
   property p_cor_set;
      corr_err_event |-> ##2 function_status[0];
   endproperty
   a_cor_set: assert property (p_cor_set) else $error("flag 0 not set");
   property p_fat_set;
      fatal_err_event |-> ##2 function_status[2];
   endproperty
   a_fat_set: assert property (p_fat_set) else $error("flag 2 not set");
   property p_nf_set;
      nonfatal_err_event |-> ##2 function_status[1];
   endproperty
   a_nf_set: assert property (p_nf_set) else $error("flag 1 not set");
   property p_sticky;
      |($past(function_status[3:0]) & ~function_status[3:0])
      |-> $past(cfg_wr && cfg_byte_en[2] && !cfg_done, 2);
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost");
endmodule

bind pfs_function_status pfs_asserts pfs_asserts_i (.*);

/* dv/pfs_sw_model.sv */
/*
   Configuration software model driving dword accesses.
   Assumes the bench calls access and spaces requests by its gap.
*/
`timescale 1ns/1ps
module pfs_sw_model
(
   // Clock
   input wire logic clk_sys,
   // Configuration access
   output logic cfg_rd,
   output logic cfg_wr,
   output logic [9:0] cfg_dw_addr,
   output logic [3:0] cfg_byte_en,
   output logic [31:0] cfg_wdata,
   input wire logic cfg_done
);
   int stalls = 0;
   initial
   begin
      cfg_rd = 1'b0;
      cfg_wr = 1'b0;
      cfg_dw_addr = 10'h000;
      cfg_byte_en = 4'h0;
      cfg_wdata = 32'h0000_0000;
   end
   // Holds the request until the answer is sampled, then scrambles
   task automatic access(input logic wr, input logic [9:0] a,
      input logic [3:0] be, input logic [31:0] d, input int gap);
      int n;
      repeat (gap) @(negedge clk_sys);
      cfg_rd = !wr;
      cfg_wr = wr;
      cfg_dw_addr = a;
      cfg_byte_en = be;
      cfg_wdata = d;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (cfg_done !== 1'b1 && n < 8);
      if (n == 8) stalls++;
      @(negedge clk_sys);
      cfg_rd = 1'b0;
      cfg_wr = 1'b0;
      cfg_dw_addr = ~a;
      cfg_byte_en = ~be;
      cfg_wdata = ~d;
   endtask
endmodule

/* dv/tb_top.sv */
/*
   Self-checking bench for the function status block.
   Assumes the checker is bound through its own file.
*/
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] ev = 8'h00;
   logic cfg_rd, cfg_wr, cfg_done, requests_pending, track_err;
   logic [9:0] cfg_dw_addr;
   logic [3:0] cfg_byte_en, flags = 4'h0;
   logic [31:0] cfg_wdata, cfg_rdata, exp_q[$];
   logic [15:0] function_status;
   logic [10:0] outstanding_cnt;
   int err_count = 0;
   int n_tests = 0;
   always #2 clk_sys = ~clk_sys;
   pfs_function_status pfs_function_status_i (.clk_sys(clk_sys),
      .rst(rst), .np_issue(ev[4]), .np_complete(ev[5]),
      .np_timeout(ev[6]), .flr_done(ev[7]), .unsup_req_event(ev[3]),
      .fatal_err_event(ev[2]), .nonfatal_err_event(ev[1]),
      .corr_err_event(ev[0]), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
      .cfg_dw_addr(cfg_dw_addr), .cfg_byte_en(cfg_byte_en),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_done(cfg_done),
      .function_status(function_status),
      .requests_pending(requests_pending),
      .outstanding_cnt(outstanding_cnt), .track_err(track_err));
   pfs_sw_model pfs_sw_model_i (.clk_sys(clk_sys), .cfg_rd(cfg_rd),
      .cfg_wr(cfg_wr), .cfg_dw_addr(cfg_dw_addr),
      .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
      .cfg_done(cfg_done));
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("errors %0d, checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Event bits: flr, timeout, complete, issue, ur, fatal, nonfatal, corr
   task automatic pulse(input logic [7:0] m);
      @(negedge clk_sys);
      ev = m;
      @(negedge clk_sys);
      ev = 8'h00;
   endtask
   task automatic rw(input logic wr, input logic [9:0] a,
      input logic [3:0] be, input logic [31:0] d, e, input int g = 1);
      exp_q.push_back(e);
      pfs_sw_model_i.access(wr, a, be, d, g);
      if (pfs_sw_model_i.stalls != 0)
      begin
         err_count++;
         report_and_stop();
      end
   endtask
   function automatic logic [31:0] img(input logic p);
      return {10'h000, p, 1'b0, flags, 16'h0000};
   endfunction
   always @(posedge clk_sys)
      if (!rst && cfg_done === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("answer count", 32'h1, 32'h0);
         else
            check("cfg_rdata", cfg_rdata, exp_q.pop_front());
      end
   initial
   begin
      logic [31:0] r;
      int i, n;
      void'($urandom(30));
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      rw(0, 10'h012, 4'hc, 32'h0, 32'h0);
      check("function_status", function_status, 32'h0);
      repeat (24)
      begin
         r = $urandom;
         pulse({4'h0, r[3:0]});
         flags |= r[3:0];
         rw(0, 10'h012, 4'hc, 32'h0, img(0), 1 + $urandom % 3);
         r = $urandom;
         i = $urandom % 2;
         if (i == 1) flags &= ~r[19:16];
         rw(1, 10'h012, {1'b1, i[0], 2'b11}, r, 32'h0);
         check("function_status", function_status, flags);
      end
      pulse(8'h0f);
      flags = 4'hf;
      fork
         pulse(8'h01);
         rw(1, 10'h012, 4'h4, 32'h000f_0000, 32'h0);
      join
      flags = 4'h1;
      rw(0, 10'h012, 4'hc, 32'h0, img(0));
      rw(0, 10'h013, 4'hf, 32'h0, 32'h0);
      rw(0, 10'h012, 4'h3, 32'h0, 32'h0);
      rw(1, 10'h011, 4'hf, 32'hffff_ffff, 32'h0);
      rw(1, 10'h012, 4'h3, 32'hffff_ffff, 32'h0);
      rw(0, 10'h012, 4'hc, 32'h0, img(0));
      n = 1 + $urandom % 4;
      repeat (n) pulse(8'h10);
      @(negedge clk_sys);
      check("requests_pending", requests_pending, 32'h1);
      for (i = 0; i < n; i++)
      begin
         rw(0, 10'h012, 4'hc, 32'h0, img(1));
         pulse(((n - i) % 2) ? 8'h40 : 8'h20);
      end
      rw(0, 10'h012, 4'hc, 32'h0, img(0));
      check("requests_pending", requests_pending, 32'h0);
      pulse(8'h10);
      pulse(8'h90);
      rw(0, 10'h012, 4'hc, 32'h0, img(0));
      check("outstanding_cnt", outstanding_cnt, 32'h0);
      check("track_err", track_err, 32'h0);
      repeat (2) pulse(8'h10);
      pulse(8'h60);
      rw(0, 10'h012, 4'hc, 32'h0, img(0));
      pulse(8'h20);
      @(negedge clk_sys);
      check("track_err", track_err, 32'h1);
      check("outstanding_cnt", outstanding_cnt, 32'h0);
      report_and_stop();
   end
endmodule
